// ### lwpc_ctrl.sv
// What this block does
// - Unused bits 31-9 and 7-1 of the wakeup/power-down word read zero and ignore writes.
// - Writing one to the wakeup-generate bit sends the transmit buffer as a wakeup; zero does nothing.
// - A valid synch break received on the bus clears the wakeup-generate bit.
// - The module software reset bit clears the wakeup-generate bit while asserted.
// - The low-power bit works in LIN and serial modes; one requests low power, zero runs normally.
// - With the low-power bit set the block tries to enter local low power.
// - If receiving with the wakeup interrupt off, low-power entry waits until reception ends.
// - The interrupt-enable set word holds enables, bit 31 bit error to bit 24 parity, all reset zero.
// - Writing zero to an enable leaves it, writing one sets it, and a read shows the enables.
// - Bit-error to no-response enables take writes only in LIN mode; the other three in any mode.
`timescale 1ns/1ps
`default_nettype none
module lwpc_ctrl (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Link engine status
	input wire logic synch_break_valid,
	input wire logic rx_active,
	input wire logic wakeup_irq_enabled,
	// Controls to the link engine
	output logic wakeup_tx,
	output logic low_power,
	output logic [31:0] irq_enable,
	output logic lin_mode,
	output logic module_software_reset,
	// Interrupt
	output logic irq
);
	lwpc_pkg::lwpc_state_t st;
	lwpc_pkg::lwpc_state_t next_st;

	function automatic logic [31:0] wake_word(input lwpc_pkg::lwpc_regs_t r);
		logic [31:0] w;
		w = 32'h00000000;
		w[lwpc_pkg::BIT_WAKE_GEN] = r.wake_generate;
		w[lwpc_pkg::BIT_POWERDOWN] = r.powerdown_req;
		return w;
	endfunction : wake_word

	always_comb begin
		logic wr;
		logic [31:0] wmask;
		logic [lwpc_pkg::EVT_WIDTH-1:0] ev;
		wr = 1'b0;
		wmask = 32'h00000000;
		ev = '0;
		next_st = st;
		// Address phase capture
		if (hready) begin
			next_st.phase.sel = hsel && htrans == lwpc_pkg::HTRANS_NONSEQ
				&& hsize == lwpc_pkg::HSIZE_WORD;
			next_st.phase.write = hwrite;
			next_st.phase.addr = haddr[7:0];
		end
		wr = st.phase.sel && st.phase.write;
		if (wr) begin
			unique case (st.phase.addr)
				lwpc_pkg::ADDR_WAKE_PWR: begin
					if (hwdata[lwpc_pkg::BIT_WAKE_GEN]) begin
						next_st.regs.wake_generate = 1'b1;
					end
					next_st.regs.powerdown_req = hwdata[lwpc_pkg::BIT_POWERDOWN];
				end
				lwpc_pkg::ADDR_IRQ_SET: begin
					wmask = st.regs.lin_mode ? (lwpc_pkg::IRQ_LIN_ONLY_MASK
						| lwpc_pkg::IRQ_ANY_MODE_MASK) : lwpc_pkg::IRQ_ANY_MODE_MASK;
					next_st.regs.irq_enable = st.regs.irq_enable | (hwdata & wmask);
				end
				lwpc_pkg::ADDR_GLOBAL_ONE: begin
					next_st.regs.lin_mode = hwdata[lwpc_pkg::BIT_LIN_MODE];
					next_st.regs.module_software_reset = hwdata[lwpc_pkg::BIT_SW_RESET];
				end
				lwpc_pkg::ADDR_EVT_STATUS: begin
					next_st.regs.evt_status = st.regs.evt_status
						& ~hwdata[lwpc_pkg::EVT_WIDTH-1:0];
				end
				lwpc_pkg::ADDR_EVT_MASK: begin
					next_st.regs.evt_mask = hwdata[lwpc_pkg::EVT_WIDTH-1:0];
				end
				default: begin
				end
			endcase
		end
		// Hardware clears of the wakeup request beat a same-cycle write
		if (st.regs.wake_generate && synch_break_valid) begin
			next_st.regs.wake_generate = 1'b0;
			ev[lwpc_pkg::EVT_WAKE_DONE] = 1'b1;
		end
		if (st.regs.module_software_reset) begin
			next_st.regs.wake_generate = 1'b0;
		end
		// Power sequencing
		unique case (st.pwr)
			lwpc_pkg::LWPC_RUN: begin
				if (st.regs.powerdown_req) begin
					if (rx_active && !wakeup_irq_enabled) begin
						next_st.pwr = lwpc_pkg::LWPC_WAIT_RX;
					end else begin
						next_st.pwr = lwpc_pkg::LWPC_LOW;
						ev[lwpc_pkg::EVT_LOWPWR_IN] = 1'b1;
					end
				end
			end
			lwpc_pkg::LWPC_WAIT_RX: begin
				if (!st.regs.powerdown_req) begin
					next_st.pwr = lwpc_pkg::LWPC_RUN;
				end else if (!rx_active || wakeup_irq_enabled) begin
					next_st.pwr = lwpc_pkg::LWPC_LOW;
					ev[lwpc_pkg::EVT_LOWPWR_IN] = 1'b1;
				end
			end
			lwpc_pkg::LWPC_LOW: begin
				if (!st.regs.powerdown_req) begin
					next_st.pwr = lwpc_pkg::LWPC_RUN;
					ev[lwpc_pkg::EVT_LOWPWR_OUT] = 1'b1;
				end
			end
		endcase
		// Set wins over a same-cycle write-one-to-clear
		next_st.regs.evt_status = next_st.regs.evt_status | ev;
		// Read data for the next data phase
		next_st.hrdata = 32'h00000000;
		if (hready && next_st.phase.sel && !hwrite) begin
			unique case (haddr[7:0])
				lwpc_pkg::ADDR_WAKE_PWR: next_st.hrdata = wake_word(next_st.regs);
				lwpc_pkg::ADDR_IRQ_SET: next_st.hrdata = next_st.regs.irq_enable;
				lwpc_pkg::ADDR_GLOBAL_ONE: begin
					next_st.hrdata[lwpc_pkg::BIT_LIN_MODE] = next_st.regs.lin_mode;
					next_st.hrdata[lwpc_pkg::BIT_SW_RESET] = next_st.regs.module_software_reset;
				end
				lwpc_pkg::ADDR_EVT_STATUS: begin
					next_st.hrdata[lwpc_pkg::EVT_WIDTH-1:0] = next_st.regs.evt_status;
				end
				lwpc_pkg::ADDR_EVT_MASK: begin
					next_st.hrdata[lwpc_pkg::EVT_WIDTH-1:0] = next_st.regs.evt_mask;
				end
				lwpc_pkg::ADDR_LINE_STATE: begin
					next_st.hrdata[1:0] = {next_st.pwr == lwpc_pkg::LWPC_WAIT_RX,
						next_st.pwr == lwpc_pkg::LWPC_LOW};
				end
				default: next_st.hrdata = 32'h00000000;
			endcase
		end
		next_st.wake_tx = next_st.regs.wake_generate;
		next_st.low_power = next_st.pwr == lwpc_pkg::LWPC_LOW;
		next_st.irq = |(next_st.regs.evt_status & next_st.regs.evt_mask);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st.regs.wake_generate <= 1'b0;
			st.regs.powerdown_req <= 1'b0;
			st.regs.irq_enable <= lwpc_pkg::IRQ_SET_RESET;
			st.regs.lin_mode <= 1'b0;
			st.regs.module_software_reset <= 1'b0;
			st.regs.evt_status <= '0;
			st.regs.evt_mask <= '0;
			st.phase <= '0;
			st.pwr <= lwpc_pkg::LWPC_RUN;
			st.hrdata <= 32'h00000000;
			st.wake_tx <= 1'b0;
			st.low_power <= 1'b0;
			st.irq <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	assign hrdata = st.hrdata;
	// Zero-wait slave: always ready, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign wakeup_tx = st.wake_tx;
	assign low_power = st.low_power;
	assign irq_enable = st.regs.irq_enable;
	assign lin_mode = st.regs.lin_mode;
	assign module_software_reset = st.regs.module_software_reset;
	assign irq = st.irq;
endmodule : lwpc_ctrl
`default_nettype wire

// ### lwpc_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module lwpc_ctrl_properties (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Link engine side
	input wire logic synch_break_valid,
	input wire logic rx_active,
	input wire logic wakeup_irq_enabled,
	input wire logic wakeup_tx,
	input wire logic low_power,
	input wire logic [31:0] irq_enable,
	input wire logic lin_mode,
	input wire logic module_software_reset
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_rx_hold;
		rx_active && !wakeup_irq_enabled && !low_power;
	endsequence
	sequence s_wake_kept;
		wakeup_tx && !synch_break_valid && !module_software_reset;
	endsequence
	chk_wake_break: assert property (wakeup_tx && synch_break_valid |=> !wakeup_tx)
		else $error("wakeup kept after synch break");
	chk_wake_swrst: assert property (module_software_reset |=> !wakeup_tx)
		else $error("wakeup kept under software reset");
	chk_wake_rise: assert property ($rose(wakeup_tx) |-> !module_software_reset)
		else $error("wakeup rose under software reset");
	chk_wake_holds: assert property (s_wake_kept |=> wakeup_tx)
		else $error("wakeup dropped without cause");
	chk_lp_postpone: assert property (s_rx_hold |=> !low_power)
		else $error("low power entered during reception");
	chk_irq_low_zero: assert property (irq_enable[23:0] == 24'h000000)
		else $error("unused enables set");
	chk_irq_sticky: assert property (($past(irq_enable) & ~irq_enable) == 32'h00000000)
		else $error("enable cleared");
	chk_irq_lin_only: assert property (!lin_mode |=> $stable(irq_enable[31:27]))
		else $error("lin enable changed outside lin mode");
endmodule : lwpc_ctrl_properties
bind lwpc_ctrl lwpc_ctrl_properties u_lwpc_ctrl_properties (.hclk(hclk), .hresetn(hresetn),
	.synch_break_valid(synch_break_valid), .rx_active(rx_active),
	.wakeup_irq_enabled(wakeup_irq_enabled), .wakeup_tx(wakeup_tx), .low_power(low_power),
	.irq_enable(irq_enable), .lin_mode(lin_mode), .module_software_reset(module_software_reset));
`default_nettype wire

// ### lwpc_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin mismatches++; \
	$display("MISMATCH %s expected %h seen %h", n, e, a); end end
module lwpc_ctrl_tb;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [31:0] hwdata = 32'h00000000;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h0;
	logic synch_break_valid = 1'b0;
	logic rx_active = 1'b0;
	logic wakeup_irq_enabled = 1'b0;
	logic [31:0] hrdata, irq_enable;
	logic hreadyout, hresp, wakeup_tx, low_power, lin_mode, module_software_reset, irq;
	int mismatches = 0;
	int checks = 0;
	int cycles = 0;
	// Read data is taken from the half cycle before the sampling edge, so no edge race
	logic [31:0] hrdata_seen = 32'h00000000;
	always @(negedge hclk) hrdata_seen = hrdata;
	lwpc_ctrl u_lwpc_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .synch_break_valid(synch_break_valid),
		.rx_active(rx_active), .wakeup_irq_enabled(wakeup_irq_enabled), .wakeup_tx(wakeup_tx),
		.low_power(low_power), .irq_enable(irq_enable), .lin_mode(lin_mode),
		.module_software_reset(module_software_reset), .irq(irq));
	initial forever #10 hclk = ~hclk;
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : tally_and_finish
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	// Waits on hready at both phases; no fixed latency assumed
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= lwpc_pkg::HTRANS_NONSEQ;
		hsize <= lwpc_pkg::HSIZE_WORD;
		hwrite <= wr;
		haddr <= {24'h000000, a};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		q = hrdata_seen;
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask : wr
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		xfer(1'b0, a, 32'h00000000, q);
		`CHK("hrdata", e, q)
		`CHK("hresp", 1'b0, hresp)
	endtask : rd_chk
	task automatic lp_chk(input logic e);
		for (int i = 0; i < 8 && low_power !== e; i++) @(posedge hclk);
		`CHK("low_power", e, low_power)
	endtask : lp_chk
	task automatic t_wake_pwr;
		rd_chk(lwpc_pkg::ADDR_WAKE_PWR, 32'h00000000);
		rd_chk(8'h20, 32'h00000000);
		wr(lwpc_pkg::ADDR_WAKE_PWR, 32'hffffffff);
		rd_chk(lwpc_pkg::ADDR_WAKE_PWR, 32'h00000101);
		`CHK("wakeup_tx", 1'b1, wakeup_tx)
		lp_chk(1'b1);
		wr(lwpc_pkg::ADDR_WAKE_PWR, 32'h00000000);
		rd_chk(lwpc_pkg::ADDR_WAKE_PWR, 32'h00000100);
		lp_chk(1'b0);
		synch_break_valid <= 1'b1;
		@(posedge hclk);
		synch_break_valid <= 1'b0;
		rd_chk(lwpc_pkg::ADDR_WAKE_PWR, 32'h00000000);
		$display("wake and power test done");
	endtask : t_wake_pwr
	task automatic t_rx_wait;
		rx_active <= 1'b1;
		wr(lwpc_pkg::ADDR_WAKE_PWR, 32'h00000001);
		repeat (10) @(posedge hclk);
		`CHK("low_power", 1'b0, low_power)
		rd_chk(lwpc_pkg::ADDR_LINE_STATE, 32'h00000002);
		rx_active <= 1'b0;
		lp_chk(1'b1);
		rd_chk(lwpc_pkg::ADDR_LINE_STATE, 32'h00000001);
		wr(lwpc_pkg::ADDR_WAKE_PWR, 32'h00000000);
		lp_chk(1'b0);
		rx_active <= 1'b1;
		wakeup_irq_enabled <= 1'b1;
		wr(lwpc_pkg::ADDR_WAKE_PWR, 32'h00000001);
		lp_chk(1'b1);
		wr(lwpc_pkg::ADDR_WAKE_PWR, 32'h00000000);
		rx_active <= 1'b0;
		$display("reception wait test done");
	endtask : t_rx_wait
	task automatic t_swrst_irq;
		wr(lwpc_pkg::ADDR_WAKE_PWR, 32'h00000100);
		wr(lwpc_pkg::ADDR_GLOBAL_ONE, 32'h00000080);
		// The clear acts one cycle after the reset bit lands
		@(posedge hclk);
		`CHK("module_software_reset", 1'b1, module_software_reset)
		rd_chk(lwpc_pkg::ADDR_WAKE_PWR, 32'h00000000);
		wr(lwpc_pkg::ADDR_WAKE_PWR, 32'h00000100);
		rd_chk(lwpc_pkg::ADDR_WAKE_PWR, 32'h00000000);
		rd_chk(lwpc_pkg::ADDR_IRQ_SET, lwpc_pkg::IRQ_SET_RESET);
		wr(lwpc_pkg::ADDR_IRQ_SET, 32'hffffffff);
		rd_chk(lwpc_pkg::ADDR_IRQ_SET, lwpc_pkg::IRQ_ANY_MODE_MASK);
		wr(lwpc_pkg::ADDR_GLOBAL_ONE, 32'h00000040);
		wr(lwpc_pkg::ADDR_IRQ_SET, 32'h80000000);
		`CHK("lin_mode", 1'b1, lin_mode)
		rd_chk(lwpc_pkg::ADDR_IRQ_SET, 32'h87000000);
		wr(lwpc_pkg::ADDR_IRQ_SET, 32'h00000000);
		rd_chk(lwpc_pkg::ADDR_IRQ_SET, 32'h87000000);
		wr(lwpc_pkg::ADDR_IRQ_SET, 32'hffffffff);
		@(posedge hclk);
		`CHK("irq_enable", 32'hff000000, irq_enable)
		$display("reset and enable test done");
	endtask : t_swrst_irq
	task automatic t_events;
		wr(lwpc_pkg::ADDR_EVT_MASK, 32'h00000000);
		rd_chk(lwpc_pkg::ADDR_EVT_STATUS, 32'h00000007);
		`CHK("irq", 1'b0, irq)
		wr(lwpc_pkg::ADDR_EVT_MASK, 32'h00000007);
		@(posedge hclk);
		`CHK("irq", 1'b1, irq)
		wr(lwpc_pkg::ADDR_EVT_STATUS, 32'h00000007);
		@(posedge hclk);
		`CHK("irq", 1'b0, irq)
		rd_chk(lwpc_pkg::ADDR_EVT_STATUS, 32'h00000000);
		$display("event test done");
	endtask : t_events
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		t_wake_pwr();
		t_rx_wait();
		t_swrst_irq();
		t_events();
		tally_and_finish();
	end
endmodule : lwpc_ctrl_tb
`default_nettype wire

// ### lwpc_pkg.sv
package lwpc_pkg;
	// Byte addresses of the register words
	localparam logic [7:0] ADDR_WAKE_PWR = 8'h00;
	localparam logic [7:0] ADDR_IRQ_SET = 8'h04;
	localparam logic [7:0] ADDR_GLOBAL_ONE = 8'h08;
	localparam logic [7:0] ADDR_EVT_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_EVT_MASK = 8'h10;
	localparam logic [7:0] ADDR_LINE_STATE = 8'h14;
	// Control word fields
	localparam int BIT_POWERDOWN = 0;
	localparam int BIT_WAKE_GEN = 8;
	localparam int BIT_LIN_MODE = 6;
	localparam int BIT_SW_RESET = 7;
	// Interrupt-enable top byte, bits 31..24
	localparam logic [31:0] IRQ_LIN_ONLY_MASK = 32'hf8000000;
	localparam logic [31:0] IRQ_ANY_MODE_MASK = 32'h07000000;
	localparam logic [31:0] IRQ_SET_RESET = 32'h00000000;
	// Event status bits
	localparam int EVT_WAKE_DONE = 0;
	localparam int EVT_LOWPWR_IN = 1;
	localparam int EVT_LOWPWR_OUT = 2;
	localparam int EVT_WIDTH = 3;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	typedef enum logic [1:0] {
		LWPC_RUN,
		LWPC_WAIT_RX,
		LWPC_LOW
	} lwpc_pwr_t;

	typedef struct packed {
		logic wake_generate;
		logic powerdown_req;
		logic [31:0] irq_enable;
		logic lin_mode;
		logic module_software_reset;
		logic [EVT_WIDTH-1:0] evt_status;
		logic [EVT_WIDTH-1:0] evt_mask;
	} lwpc_regs_t;

	typedef struct packed {
		logic sel;
		logic write;
		logic [7:0] addr;
	} lwpc_phase_t;

	typedef struct packed {
		lwpc_regs_t regs;
		lwpc_phase_t phase;
		lwpc_pwr_t pwr;
		logic [31:0] hrdata;
		logic wake_tx;
		logic low_power;
		logic irq;
	} lwpc_state_t;
endpackage : lwpc_pkg
